// file: verilog/can_filter_map.vh
`ifndef CAN_FILTER_MAP_VH
`define CAN_FILTER_MAP_VH
// Register byte offsets (32 entries, one word each, then two control words)
`define AF_PATTERN_BASE 8'h00
`define AF_ENABLE_ADDR 8'h80
`define AF_HITS_ADDR 8'h84
`define AF_ADDR_BITS 8
// Pattern entry field layout
`define AF_STD_HI 31
`define AF_STD_LO 21
`define AF_FMT_BIT 19
`define AF_EXT_HI 17
`define AF_EXT_LO 0
// Mask of implemented pattern bits: 31..21, 19, 17..0
`define AF_IMPL_MASK 32'hffeb_ffff
`define AF_RESET_VAL 32'h0000_0000
// AHB encodings
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HRESP_OKAY 1'h0
`endif

// file: verilog/filter_entry_mem.v
`timescale 1ns/10ps
`include "can_filter_map.vh"
// Small register-based store of the filter entries, registered read port
module filter_entry_mem #(
  parameter DEPTH = 32, // Number of entries
  parameter AW = 5 // Index width
) (
  input wire clk, // Peripheral clock
  input wire rst_n, // Async reset, active low
  input wire wr_en, // Write strobe
  input wire [AW-1:0] wr_idx, // Write index
  input wire [31:0] wr_data, // Write data, already masked
  input wire [AW-1:0] rd_idx, // Read index
  output reg [31:0] rd_data, // Registered read data
  output wire [32*DEPTH-1:0] all_data // Every entry, for the comparators
);
  reg [31:0] mem [0:DEPTH-1]; // Entry storage
  genvar g;
  // Each entry is its own flop row so all comparators see it at once
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_row
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem[g] <= `AF_RESET_VAL;
        end else if (wr_en && wr_idx == g) begin
          mem[g] <= wr_data;
        end
      end
      assign all_data[32*g+31:32*g] = mem[g];
    end
  endgenerate
  // Read data out of a register
  // A read issued while the same entry is being written sees the new word,
  // so a write followed at once by a read of that entry returns fresh data
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
    end else if (wr_en && wr_idx == rd_idx) begin
      rd_data <= wr_data; // Forward the word being written
    end else begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule // filter_entry_mem

// file: verilog/filter_match.v
`timescale 1ns/10ps
`include "can_filter_map.vh"
// Combinational compare of one entry against an incoming identifier
module filter_match (
  input wire [31:0] pattern, // Stored entry
  input wire [10:0] msg_std_id, // Incoming standard identifier
  input wire [17:0] msg_ext_id, // Incoming extended identifier bits
  input wire msg_is_ext, // Incoming frame is extended format
  output wire hit // Entry matches
);
  wire std_ok; // Standard bits all agree
  wire ext_ok; // Extended bits all agree
  wire fmt_ok; // Frame format agrees with selector
  assign std_ok = (pattern[`AF_STD_HI:`AF_STD_LO] == msg_std_id);
  assign ext_ok = (pattern[`AF_EXT_HI:`AF_EXT_LO] == msg_ext_id);
  // Selector set takes only extended frames, clear only standard
  assign fmt_ok = (pattern[`AF_FMT_BIT] == msg_is_ext);
  // Extended frames need all 29 bits, standard frames 11
  assign hit = fmt_ok && std_ok && (!msg_is_ext || ext_ok);
endmodule // filter_match

// file: verilog/can_acceptance_filter.v
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/10ps
`include "can_filter_map.vh"
module can_acceptance_filter #(
  parameter NUM_FILTERS = 32, // Entries
  parameter IDX_W = 5 // Entry index width
) (
  input wire clk, // 40 MHz peripheral clock
  input wire rst_n, // Async reset, active low
  input wire hsel, // AHB slave select
  input wire [31:0] haddr, // AHB address
  input wire [1:0] htrans, // AHB transfer type
  input wire hwrite, // AHB write
  input wire [2:0] hsize, // AHB size
  input wire [31:0] hwdata, // AHB write data
  input wire hready, // AHB bus ready
  output reg [31:0] hrdata, // AHB read data
  output wire hreadyout, // AHB slave ready
  output wire hresp, // AHB response
  input wire msg_valid, // Identifier presented this cycle
  input wire [10:0] msg_std_id, // Standard identifier
  input wire [17:0] msg_ext_id, // Extended identifier bits
  input wire msg_is_ext, // Frame is extended format
  output reg match_valid, // Registered match result valid
  output reg match_any, // Some enabled filter hit
  output reg [IDX_W-1:0] match_idx, // Lowest hitting filter
  output reg [NUM_FILTERS-1:0] match_vec // All enabled hitting filters
);
  // Address phase capture
  reg dp_write; // Pending write data phase
  reg dp_read; // Pending read data phase
  reg [`AF_ADDR_BITS-1:0] dp_addr; // Captured address
  reg [NUM_FILTERS-1:0] filter_n_active; // Per-filter enable bits
  reg [NUM_FILTERS-1:0] hit_count_sticky; // Sticky record of hits
  wire [32*NUM_FILTERS-1:0] all_pat; // All entries
  wire [NUM_FILTERS-1:0] raw_hit; // Per-entry compare
  wire [31:0] mem_rd; // Registered entry read
  wire addr_valid; // Address phase accepted
  wire dp_is_pat; // Data phase addresses an entry
  wire [IDX_W-1:0] dp_idx; // Entry index of data phase
  wire mem_wr; // Allowed entry write
  reg [IDX_W-1:0] next_idx; // Lowest-hit encoder result
  integer k;

  assign addr_valid = hsel && hready &&
                      (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
  // Registered reads need no wait state: memory read issued at address phase
  assign hreadyout = 1'b1;
  assign hresp = `HRESP_OKAY;
  assign dp_is_pat = (dp_addr < `AF_ENABLE_ADDR);
  assign dp_idx = dp_addr[IDX_W+1:2];

  // Write lands only while the target filter is disabled
  assign mem_wr = dp_write && dp_is_pat && !filter_n_active[dp_idx];
  filter_entry_mem #(
    .DEPTH(NUM_FILTERS),
    .AW(IDX_W)
  ) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(mem_wr),
    .wr_idx(dp_idx),
    .wr_data(hwdata & `AF_IMPL_MASK),
    .rd_idx(haddr[IDX_W+1:2]),
    .rd_data(mem_rd),
    .all_data(all_pat)
  );

  // One comparator per entry
  genvar g;
  generate
    for (g = 0; g < NUM_FILTERS; g = g + 1) begin : g_cmp
      filter_match u_cmp (
        .pattern(all_pat[32*g+31:32*g]),
        .msg_std_id(msg_std_id),
        .msg_ext_id(msg_ext_id),
        .msg_is_ext(msg_is_ext),
        .hit(raw_hit[g])
      );
    end
  endgenerate

  // Bus address capture
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= {`AF_ADDR_BITS{1'b0}};
    end else begin
      dp_write <= addr_valid && hwrite;
      dp_read <= addr_valid && !hwrite;
      if (addr_valid) begin
        dp_addr <= haddr[`AF_ADDR_BITS-1:0];
      end
    end
  end

  // Control registers: enables writable, hit flags cleared by writing one
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_n_active <= {NUM_FILTERS{1'b0}};
      hit_count_sticky <= {NUM_FILTERS{1'b0}};
    end else begin
      if (dp_write && dp_addr == `AF_ENABLE_ADDR) begin
        filter_n_active <= hwdata[NUM_FILTERS-1:0];
      end
      // A new hit wins over a clear in the same cycle
      if (dp_write && dp_addr == `AF_HITS_ADDR) begin
        hit_count_sticky <= (hit_count_sticky & ~hwdata[NUM_FILTERS-1:0]) |
                            (msg_valid ? match_src(raw_hit, filter_n_active) :
                             {NUM_FILTERS{1'b0}});
      end else if (msg_valid) begin
        hit_count_sticky <= hit_count_sticky | (raw_hit & filter_n_active);
      end
    end
  end

  function [NUM_FILTERS-1:0] match_src;
    input [NUM_FILTERS-1:0] h;
    input [NUM_FILTERS-1:0] e;
    begin
      match_src = h & e;
    end
  endfunction

  // Read mux: entry reads come from the memory's registered port
  always @* begin
    hrdata = 32'h0000_0000;
    if (dp_read) begin
      if (dp_is_pat) begin
        hrdata = mem_rd & `AF_IMPL_MASK;
      end else if (dp_addr == `AF_ENABLE_ADDR) begin
        hrdata[NUM_FILTERS-1:0] = filter_n_active;
      end else if (dp_addr == `AF_HITS_ADDR) begin
        hrdata[NUM_FILTERS-1:0] = hit_count_sticky;
      end
    end
  end

  // Lowest-numbered enabled hit
  always @* begin
    next_idx = {IDX_W{1'b0}};
    for (k = NUM_FILTERS - 1; k >= 0; k = k - 1) begin
      if (raw_hit[k] && filter_n_active[k]) begin
        next_idx = k[IDX_W-1:0];
      end
    end
  end

  // Registered match result, one cycle after msg_valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_valid <= 1'b0;
      match_any <= 1'b0;
      match_idx <= {IDX_W{1'b0}};
      match_vec <= {NUM_FILTERS{1'b0}};
    end else begin
      match_valid <= msg_valid;
      match_any <= msg_valid && |(raw_hit & filter_n_active);
      // Index reads zero whenever no result is presented
      match_idx <= msg_valid ? next_idx : {IDX_W{1'b0}};
      match_vec <= msg_valid ? (raw_hit & filter_n_active) : {NUM_FILTERS{1'b0}};
    end
  end
endmodule // can_acceptance_filter

// file: testbench/can_filter_assertions.sv
`timescale 1ns/10ps
// Ties match results and entry reads to their causes
module can_filter_assertions #(
  parameter NUM_FILTERS = 32, // Entries
  parameter IDX_W = 5 // Index width
) (
  input wire clk, // Clock
  input wire rst_n, // Reset, active low
  input wire hsel, // Select
  input wire [31:0] haddr, // Address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write
  input wire hready, // Bus ready
  input wire [31:0] hrdata, // Read data
  input wire msg_valid, // Identifier strobe
  input wire match_valid, // Result strobe
  input wire match_any, // Any hit
  input wire [IDX_W-1:0] match_idx, // Lowest hit
  input wire [NUM_FILTERS-1:0] match_vec // Hit vector
);
  reg rd_ph; // Entry read now in data phase
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Mark data phases of entry reads
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_ph <= 1'b0;
    else rd_ph <= hsel && hready && htrans[1] && !hwrite && haddr < 32'h80;
  end
  valid_delay_a: assert property (1 |=> match_valid == $past(msg_valid))
    else $error("result strobe not one cycle after identifier");
  any_vec_a: assert property (match_any == |match_vec)
    else $error("any flag disagrees with hit vector");
  idx_hit_a: assert property (match_any |-> match_vec[match_idx])
    else $error("index points at a filter that did not hit");
  idx_low_a: assert property ((match_vec & ((1 << match_idx) - 1)) == 0)
    else $error("index is not the lowest hit");
  rsv_zero_a: assert property (rd_ph |-> !hrdata[20] && !hrdata[18])
    else $error("unimplemented entry bits read nonzero");
  idle_clear_a: assert property (!match_valid |-> match_vec == 0 && match_idx == 0)
    else $error("idle result not cleared");
endmodule // can_filter_assertions

// file: testbench/id_source.sv
`timescale 1ns/10ps
// Receive path stand-in: presents one decoded identifier per call
module id_source (
  input wire clk, // Clock
  output reg msg_valid, // Identifier strobe
  output reg [10:0] msg_std_id, // Standard identifier
  output reg [17:0] msg_ext_id, // Extended bits
  output reg msg_is_ext // Extended frame
);
  initial begin
    msg_valid = 1'b0;
    msg_std_id = 11'h0;
    msg_ext_id = 18'h0;
    msg_is_ext = 1'b0;
  end
  // One-cycle strobe; lines then show the inverse so stale ids never pass
  task send(input [10:0] s, input [17:0] e, input x);
    msg_valid <= 1'b1;
    msg_std_id <= s;
    msg_ext_id <= e;
    msg_is_ext <= x;
    @(posedge clk);
    msg_valid <= 1'b0;
    msg_std_id <= ~s;
    msg_ext_id <= ~e;
    msg_is_ext <= ~x;
  endtask
endmodule // id_source

// file: testbench/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  reg clk, rst_n, hsel, hwrite; // Clock, reset, bus controls
  reg [1:0] htrans; // Transfer type
  reg [31:0] haddr, hwdata; // Address, write data
  reg [66:0] tv [0:5]; // {std, fmt, ext, idx, vec} per identifier
  wire [31:0] hrdata, match_vec; // Read data, hits
  wire hreadyout, hresp, msg_valid, msg_is_ext, match_valid, match_any; // Strobes
  wire [10:0] msg_std_id; // Standard identifier
  wire [17:0] msg_ext_id; // Extended bits
  wire [4:0] match_idx; // Lowest hit
  integer fails = 0, num_checks = 0, i;
  can_acceptance_filter DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .msg_valid(msg_valid),
    .msg_std_id(msg_std_id), .msg_ext_id(msg_ext_id), .msg_is_ext(msg_is_ext),
    .match_valid(match_valid), .match_any(match_any), .match_idx(match_idx),
    .match_vec(match_vec));
  id_source src (.clk(clk), .msg_valid(msg_valid), .msg_std_id(msg_std_id),
    .msg_ext_id(msg_ext_id), .msg_is_ext(msg_is_ext));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Single word transfer; both phases wait on ready
  task xfer(input [31:0] a, input w, input [31:0] d, input [31:0] e);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    if (!w) `CHK(hrdata, e)
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog far beyond the roughly 45 cycles the tests take
  initial begin
    #100000;
    fails++;
    test_done;
  end
  initial begin
    tv[0] = {11'h7ff, 1'b1, 18'h3ffff, 5'h3, 32'h8};
    tv[1] = {11'h7ff, 1'b0, 18'h3ffff, 5'h0, 32'h0};
    tv[2] = {11'h123, 1'b0, 18'h15555, 5'h5, 32'h20};
    tv[3] = {11'h123, 1'b1, 18'h00000, 5'h0, 32'h0};
    tv[4] = {11'h7ff, 1'b1, 18'h3fffe, 5'h0, 32'h0};
    tv[5] = {11'h7fe, 1'b1, 18'h3ffff, 5'h0, 32'h0};
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    xfer(32'h00, 1'b0, 32'h0, 32'h0);
    xfer(32'h0c, 1'b1, 32'hffff_ffff, 32'h0);
    xfer(32'h0c, 1'b0, 32'h0, 32'hffeb_ffff);
    xfer(32'h90, 1'b0, 32'h0, 32'h0);
    xfer(32'h14, 1'b1, 32'h2460_0000, 32'h0);
    xfer(32'h80, 1'b1, 32'h28, 32'h0);
    $display("test 1 done");
    // Format and identifier bits, accepted and refused
    for (i = 0; i < 6; i++) begin
      src.send(tv[i][66:56], tv[i][54:37], tv[i][55]);
      #1;
      `CHK({match_valid, match_idx, match_vec}, {1'b1, tv[i][36:0]})
      `CHK(match_any, |tv[i][31:0])
      @(posedge clk);
    end
    xfer(32'h84, 1'b0, 32'h0, 32'h28);
    // Writing one clears that sticky hit only
    xfer(32'h84, 1'b1, 32'h8, 32'h0);
    xfer(32'h84, 1'b0, 32'h0, 32'h20);
    $display("test 2 done");
    xfer(32'h0c, 1'b1, 32'h0, 32'h0);
    xfer(32'h0c, 1'b0, 32'h0, 32'hffeb_ffff);
    xfer(32'h80, 1'b1, 32'h0, 32'h0);
    xfer(32'h0c, 1'b1, 32'h0, 32'h0);
    xfer(32'h0c, 1'b0, 32'h0, 32'h0);
    $display("test 3 done");
    test_done;
  end
endmodule // tb
bind can_acceptance_filter can_filter_assertions #(.NUM_FILTERS(NUM_FILTERS), .IDX_W(IDX_W))
  chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .msg_valid(msg_valid),
  .match_valid(match_valid), .match_any(match_any), .match_idx(match_idx),
  .match_vec(match_vec));
